// ---- cmo_pkg.sv ----
// Package for the cache and TLB maintenance command block.
// Shared by the interface, the core-side issuer and the command engine.
package cmo_pkg;

	// Primary register numbers of the maintenance space
	localparam logic [3:0] CRN_CACHE = 4'h7;
	localparam logic [3:0] CRN_TLB = 4'h8;
	localparam logic [3:0] CRN_CLOCK = 4'h9;
	localparam logic [3:0] CRN_TLOCK = 4'hA;

	// Secondary opcodes
	localparam logic [2:0] OP2_0 = 3'h0;
	localparam logic [2:0] OP2_1 = 3'h1;
	localparam logic [2:0] OP2_DRAIN = 3'h4;
	localparam logic [2:0] OP2_ALLOC = 3'h5;
	localparam logic [2:0] OP2_BTT = 3'h6;

	// Operand register selects
	localparam logic [3:0] SEL_ICL = 4'h1;
	localparam logic [3:0] SEL_DCL = 4'h2;
	localparam logic [3:0] SEL_ITLK = 4'h4;
	localparam logic [3:0] SEL_I = 4'h5;
	localparam logic [3:0] SEL_D = 4'h6;
	localparam logic [3:0] SEL_ID = 4'h7;
	localparam logic [3:0] SEL_DTLK = 4'h8;
	localparam logic [3:0] SEL_CLEAN = 4'hA;

	// Line tag field of the data word
	localparam int TAG_MSB = 31;
	localparam int TAG_LSB = 5;
	localparam int TAG_W = TAG_MSB - TAG_LSB + 1;

	// Lock mode bit of the data cache lock register
	localparam int LOCK_BIT = 0;
	localparam logic LOCK_RESET = 1'b0;

	// Action codes sent to the cache and TLB hardware
	typedef enum logic [4:0] {
		ACT_NONE, ACT_INV_ID_BTT, ACT_INV_I_BTT, ACT_INV_D, ACT_INV_ILINE,
		ACT_INV_DLINE, ACT_CLEAN_DLINE, ACT_DRAIN, ACT_INV_BTT, ACT_ALLOC,
		ACT_INV_ITLB_DTLB, ACT_INV_ITLB, ACT_INV_DTLB, ACT_INV_IENT,
		ACT_INV_DENT, ACT_LOCK_ILINE, ACT_UNLOCK_I, ACT_UNLOCK_D,
		ACT_TLOCK_I, ACT_TLOCK_D, ACT_TUNLOCK_I, ACT_TUNLOCK_D
	} cmo_act_t;

	// Decode of one write command; unlisted codes become ACT_NONE
	function automatic cmo_act_t cmo_decode(input logic [3:0] crn,
			input logic [2:0] op2, input logic [3:0] sel);
		cmo_act_t a;
		a = ACT_NONE;
		unique case (crn)
			CRN_CACHE: begin
				if (op2 == OP2_0 && sel == SEL_ID) a = ACT_INV_ID_BTT;
				if (op2 == OP2_0 && sel == SEL_I) a = ACT_INV_I_BTT;
				if (op2 == OP2_0 && sel == SEL_D) a = ACT_INV_D;
				if (op2 == OP2_1 && sel == SEL_I) a = ACT_INV_ILINE;
				if (op2 == OP2_1 && sel == SEL_D) a = ACT_INV_DLINE;
				if (op2 == OP2_1 && sel == SEL_CLEAN) a = ACT_CLEAN_DLINE;
				if (op2 == OP2_DRAIN && sel == SEL_CLEAN) a = ACT_DRAIN;
				if (op2 == OP2_BTT && sel == SEL_I) a = ACT_INV_BTT;
				if (op2 == OP2_ALLOC && sel == SEL_DCL) a = ACT_ALLOC;
			end
			CRN_TLB: begin
				if (op2 == OP2_0 && sel == SEL_ID) a = ACT_INV_ITLB_DTLB;
				if (op2 == OP2_0 && sel == SEL_I) a = ACT_INV_ITLB;
				if (op2 == OP2_0 && sel == SEL_D) a = ACT_INV_DTLB;
				if (op2 == OP2_1 && sel == SEL_I) a = ACT_INV_IENT;
				if (op2 == OP2_1 && sel == SEL_D) a = ACT_INV_DENT;
			end
			CRN_CLOCK: begin
				if (op2 == OP2_0 && sel == SEL_ICL) a = ACT_LOCK_ILINE;
				if (op2 == OP2_1 && sel == SEL_ICL) a = ACT_UNLOCK_I;
				if (op2 == OP2_1 && sel == SEL_DCL) a = ACT_UNLOCK_D;
			end
			CRN_TLOCK: begin
				if (op2 == OP2_0 && sel == SEL_ITLK) a = ACT_TLOCK_I;
				if (op2 == OP2_0 && sel == SEL_DTLK) a = ACT_TLOCK_D;
				if (op2 == OP2_1 && sel == SEL_ITLK) a = ACT_TUNLOCK_I;
				if (op2 == OP2_1 && sel == SEL_DTLK) a = ACT_TUNLOCK_D;
			end
			default: a = ACT_NONE;
		endcase
		return a;
	endfunction

endpackage

// ---- cmo_if.sv ----
// Command path between the core's coprocessor write/read issue and the
// maintenance command engine. One clock, shared with both ends.
`timescale 1ns/100ps
interface cmo_if (input wire logic CLK);
	import cmo_pkg::*;
	logic cmd_valid;
	logic cmd_ready;
	logic cmd_read;
	logic [3:0] cmd_crn;
	logic [2:0] cmd_op2;
	logic [3:0] operand_reg_select;
	logic [31:0] cmd_data;
	logic done;
	logic parity_fault;
	logic [31:0] rd_data;

	modport engine (input CLK, cmd_valid, cmd_read, cmd_crn, cmd_op2,
		operand_reg_select, cmd_data, output cmd_ready, done, parity_fault,
		rd_data);
	modport core (input CLK, cmd_ready, done, parity_fault, rd_data,
		output cmd_valid, cmd_read, cmd_crn, cmd_op2, operand_reg_select,
		cmd_data);
endinterface

// ---- cmo_core.sv ----
// Core end: issues one maintenance write (or lock mode read) per request.
// Assumes the user side holds its request until accepted.
`timescale 1ns/100ps
module cmo_core
	import cmo_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Command link
	cmo_if.core LINK,
	// User request
	input wire logic REQ_VALID,
	output logic REQ_READY,
	input wire logic REQ_READ,
	input wire logic [3:0] REQ_CRN,
	input wire logic [2:0] REQ_OP2,
	input wire logic [3:0] REQ_SEL,
	input wire logic [31:0] REQ_DATA,
	// Completion
	output logic RSP_DONE,
	output logic RSP_FAULT,
	output logic [31:0] RSP_DATA
);
	typedef struct packed {
		logic busy;
		logic sent;
		logic rd;
		logic [3:0] crn;
		logic [2:0] op2;
		logic [3:0] sel;
		logic [31:0] data;
		logic done;
		logic fault;
		logic [31:0] rdata;
	} cmo_core_st_t;

	cmo_core_st_t s_reg, s_next;

	// Only the data cache lock register may be read; other reads are
	// never issued since their effect is undefined.
	function automatic logic read_ok(input logic [3:0] crn,
			input logic [2:0] op2, input logic [3:0] sel);
		return crn == CRN_CLOCK && op2 == OP2_0 && sel == SEL_DCL;
	endfunction

	assign REQ_READY = !s_reg.busy;

	always_comb begin
		s_next = s_reg;
		s_next.done = 1'b0;
		s_next.fault = 1'b0;
		if (!s_reg.busy && REQ_VALID) begin
			if (REQ_READ && !read_ok(REQ_CRN, REQ_OP2, REQ_SEL)) begin
				s_next.done = 1'b1;
			end else begin
				s_next.busy = 1'b1;
				s_next.rd = REQ_READ;
				s_next.crn = REQ_CRN;
				s_next.op2 = REQ_OP2;
				s_next.sel = REQ_SEL;
				s_next.data = REQ_DATA;
			end
		end else if (s_reg.busy && !s_reg.sent && LINK.cmd_ready) begin
			// Valid drops once taken, so the engine runs it only once
			s_next.sent = 1'b1;
		end else if (s_reg.busy && LINK.done) begin
			s_next.busy = 1'b0;
			s_next.sent = 1'b0;
			s_next.done = 1'b1;
			s_next.fault = LINK.parity_fault;
			if (s_reg.rd) begin
				s_next.rdata = LINK.rd_data;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	// Valid held until accepted; done may arrive later than acceptance
	assign LINK.cmd_valid = s_reg.busy && !s_reg.sent;
	assign LINK.cmd_read = s_reg.rd;
	assign LINK.cmd_crn = s_reg.crn;
	assign LINK.cmd_op2 = s_reg.op2;
	assign LINK.operand_reg_select = s_reg.sel;
	assign LINK.cmd_data = s_reg.data;
	assign RSP_DONE = s_reg.done;
	assign RSP_FAULT = s_reg.fault;
	assign RSP_DATA = s_reg.rdata;
endmodule // cmo_core

// ---- cmo_engine.sv ----
// Maintenance command engine: decodes commands from the core and drives
// one-cycle action pulses to the caches and TLBs, and a drain request
// held until the write and fill buffers are empty.
// Assumes cache and TLB hardware reports buffer idle and line presence.
`timescale 1ns/100ps
module cmo_engine
	import cmo_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Command link
	cmo_if.engine LINK,
	// Status from the memory system
	input wire logic WBUF_EMPTY,
	input wire logic FBUF_EMPTY,
	input wire logic MEM_IDLE,
	input wire logic DLINE_HIT,
	input wire logic VICTIM_DIRTY,
	input wire logic EVICT_DONE,
	input wire logic CLEAN_DONE,
	input wire logic CLEAN_PERR,
	// Action outputs
	output logic ACT_VALID,
	output cmo_act_t ACT_CODE,
	output logic [31:0] ACT_ADDR,
	output logic [TAG_W-1:0] ALLOC_TAG,
	output logic ALLOC_DIRTY,
	output logic ALLOC_MAIN_ONLY,
	output logic PROBE,
	output logic EVICT_REQ,
	output logic CLEAN_REQ,
	output logic DRAIN_REQ,
	output logic DLOCK_MODE
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_DRAIN, ST_AWAIT_MEM, ST_PROBE, ST_EVICT, ST_CLEAN,
		ST_DONE
	} cmo_state_t;

	typedef struct packed {
		cmo_state_t state;
		cmo_act_t act;
		logic [31:0] addr;
		logic act_valid;
		logic done;
		logic perr;
		logic lock_mode;
	} cmo_eng_st_t;

	cmo_eng_st_t s_reg, s_next;
	cmo_act_t dec;

	// Data cache lock register: the only command space that may be read
	function automatic logic is_lock_reg(input logic [3:0] crn,
			input logic [2:0] op2, input logic [3:0] sel);
		return crn == CRN_CLOCK && op2 == OP2_0 && sel == SEL_DCL;
	endfunction

	// Enable bits of the caches and MMU are not inputs here, so no command
	// can depend on them and no enable change can touch cache state.
	assign dec = cmo_decode(LINK.cmd_crn, LINK.cmd_op2,
		LINK.operand_reg_select);

	assign LINK.cmd_ready = s_reg.state == ST_IDLE;

	always_comb begin
		s_next = s_reg;
		s_next.act_valid = 1'b0;
		s_next.done = 1'b0;
		unique case (s_reg.state)
			ST_IDLE: begin
				s_next.perr = 1'b0;
				if (LINK.cmd_valid) begin
					s_next.addr = LINK.cmd_data;
					s_next.act = dec;
					s_next.state = ST_DONE;
					if (LINK.cmd_read) begin
						// Only lock mode read reaches here; others undefined
						s_next.act = ACT_NONE;
					end else if (dec == ACT_DRAIN) begin
						s_next.state = ST_DRAIN;
					end else if (dec == ACT_ALLOC) begin
						s_next.state = ST_AWAIT_MEM;
					end else if (dec == ACT_CLEAN_DLINE) begin
						s_next.state = ST_CLEAN;
					end else if (is_lock_reg(LINK.cmd_crn, LINK.cmd_op2,
							LINK.operand_reg_select)) begin
						s_next.lock_mode = LINK.cmd_data[LOCK_BIT];
					end else begin
						// Every action is a single-cycle pulse; none
						// unlisted reaches the cache hardware
						s_next.act_valid = dec != ACT_NONE;
					end
				end
			end
			ST_DRAIN: begin
				if (WBUF_EMPTY && FBUF_EMPTY) begin
					s_next.state = ST_DONE;
				end
			end
			ST_AWAIT_MEM: begin
				if (MEM_IDLE) begin
					s_next.state = ST_PROBE;
				end
			end
			ST_PROBE: begin
				if (DLINE_HIT) begin
					s_next.state = ST_DONE;
				end else if (VICTIM_DIRTY) begin
					s_next.state = ST_EVICT;
				end else begin
					s_next.act_valid = 1'b1;
					s_next.state = ST_DONE;
				end
			end
			ST_EVICT: begin
				if (EVICT_DONE) begin
					s_next.act_valid = 1'b1;
					s_next.state = ST_DONE;
				end
			end
			ST_CLEAN: begin
				if (CLEAN_DONE) begin
					s_next.perr = CLEAN_PERR;
					s_next.state = ST_DONE;
				end
			end
			ST_DONE: begin
				s_next.done = 1'b1;
				s_next.state = ST_IDLE;
			end
			// The spare state code falls back to idle rather than hang
			default: begin
				s_next.state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			s_reg <= '{state: ST_IDLE,
				act: ACT_NONE,
				addr: '0,
				act_valid: 1'b0,
				done: 1'b0,
				perr: 1'b0,
				lock_mode: LOCK_RESET};
		end else begin
			s_reg <= s_next;
		end
	end

	// Address passed raw: no permission check, never a translation fault
	assign ACT_ADDR = s_reg.addr;
	assign ACT_VALID = s_reg.act_valid;
	// Line invalidate of the instruction cache carries its own code and
	// never hits the branch table; a table invalidate needs its own command.
	assign ACT_CODE = s_reg.act;
	assign ALLOC_TAG = s_reg.addr[TAG_MSB:TAG_LSB];
	// Data bytes of the new line are not written by this block
	assign ALLOC_DIRTY = 1'b0;
	assign ALLOC_MAIN_ONLY = 1'b1;
	assign PROBE = s_reg.state == ST_PROBE;
	assign EVICT_REQ = s_reg.state == ST_EVICT;
	assign CLEAN_REQ = s_reg.state == ST_CLEAN;
	assign DRAIN_REQ = s_reg.state == ST_DRAIN;
	assign DLOCK_MODE = s_reg.lock_mode;
	assign LINK.done = s_reg.done;
	assign LINK.parity_fault = s_reg.done && s_reg.perr;
	assign LINK.rd_data = {31'h0, s_reg.lock_mode};
endmodule // cmo_engine

// ---- cmo_checker.sv ----
// Checker for the maintenance command link between core and engine.
// Sees only the link signals; tb instantiates it beside the interface.
`timescale 1ns/100ps
module cmo_checker
	import cmo_pkg::*;
(
	// Clock and reset
	input wire logic CLK,
	input wire logic RST,
	// Command link
	input wire logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic cmd_read,
	input wire logic [3:0] cmd_crn,
	input wire logic [2:0] cmd_op2,
	input wire logic [3:0] operand_reg_select,
	input wire logic [31:0] cmd_data,
	input wire logic done,
	input wire logic parity_fault,
	input wire logic [31:0] rd_data
);
	logic acc;
	logic is_clean;
	logic is_wait;
	logic busy_reg;
	logic clean_reg;
	logic rd_reg;
	logic lock_reg;
	assign acc = cmd_valid && cmd_ready;
	assign is_clean = cmd_crn == CRN_CACHE && cmd_op2 == OP2_1
		&& operand_reg_select == SEL_CLEAN;
	// Drain, allocate and clean wait on the memory system, so no bound
	assign is_wait = is_clean || (cmd_crn == CRN_CACHE
		&& ((cmd_op2 == OP2_DRAIN && operand_reg_select == SEL_CLEAN)
		|| (cmd_op2 == OP2_ALLOC && operand_reg_select == SEL_DCL)));
	always_ff @(posedge CLK) begin
		if (RST) begin
			busy_reg <= 1'b0;
			clean_reg <= 1'b0;
			rd_reg <= 1'b0;
			lock_reg <= LOCK_RESET;
		end else if (acc) begin
			busy_reg <= 1'b1;
			clean_reg <= is_clean;
			rd_reg <= cmd_read;
			if (!cmd_read && cmd_crn == CRN_CLOCK && cmd_op2 == OP2_0
				&& operand_reg_select == SEL_DCL) begin
				lock_reg <= cmd_data[LOCK_BIT];
			end
		end else if (done) begin
			busy_reg <= 1'b0;
		end
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	sequence s_fast_cmd;
		cmd_valid && cmd_ready && !is_wait;
	endsequence
	sequence s_quick_done;
		##[1:2] done;
	endsequence
	a_read_lock_only: assert property (cmd_valid && cmd_read |->
		cmd_crn == CRN_CLOCK && cmd_op2 == OP2_0
		&& operand_reg_select == SEL_DCL) else $error("illegal read sent");
	a_fast_done: assert property (s_fast_cmd |-> s_quick_done)
		else $error("command did not complete");
	a_fault_clean_only: assert property (parity_fault |->
		done && clean_reg) else $error("parity fault outside clean");
	a_fault_one_cycle: assert property (parity_fault |=>
		!parity_fault) else $error("fault stands too long");
	a_done_one_cycle: assert property (done |=> !done)
		else $error("done stands too long");
	a_busy_refuse: assert property (acc |=> !cmd_ready)
		else $error("ready while busy");
	a_done_has_cmd: assert property (done |-> busy_reg)
		else $error("done without command");
	a_lock_read: assert property (done && rd_reg |->
		rd_data == {31'h0, lock_reg}) else $error("lock mode read wrong");
endmodule // cmo_checker

// ---- tb.sv ----
// Testbench: drives the core user side and the engine status inputs.
// Assumes cmo_pkg, cmo_if, cmo_core, cmo_engine and cmo_checker compiled.
`timescale 1ns/100ps
module tb;
	import cmo_pkg::*;
	typedef struct packed {
		logic [3:0] crn;
		logic [2:0] op2;
		logic [3:0] sel;
		cmo_act_t act;
	} cmo_ent_t;
	localparam cmo_ent_t TAB [18] = '{
		'{4'h7, 3'h0, 4'h7, ACT_INV_ID_BTT}, '{4'h7, 3'h0, 4'h5, ACT_INV_I_BTT},
		'{4'h7, 3'h0, 4'h6, ACT_INV_D}, '{4'h7, 3'h1, 4'h5, ACT_INV_ILINE},
		'{4'h7, 3'h1, 4'h6, ACT_INV_DLINE}, '{4'h7, 3'h6, 4'h5, ACT_INV_BTT},
		'{4'h8, 3'h0, 4'h7, ACT_INV_ITLB_DTLB}, '{4'h8, 3'h0, 4'h5, ACT_INV_ITLB},
		'{4'h8, 3'h0, 4'h6, ACT_INV_DTLB}, '{4'h8, 3'h1, 4'h5, ACT_INV_IENT},
		'{4'h8, 3'h1, 4'h6, ACT_INV_DENT}, '{4'h9, 3'h0, 4'h1, ACT_LOCK_ILINE},
		'{4'h9, 3'h1, 4'h1, ACT_UNLOCK_I}, '{4'h9, 3'h1, 4'h2, ACT_UNLOCK_D},
		'{4'hA, 3'h0, 4'h4, ACT_TLOCK_I}, '{4'hA, 3'h0, 4'h8, ACT_TLOCK_D},
		'{4'hA, 3'h1, 4'h4, ACT_TUNLOCK_I}, '{4'hA, 3'h1, 4'h8, ACT_TUNLOCK_D}};
	localparam cmo_ent_t BAD [5] = '{
		'{4'h7, 3'h2, 4'h5, ACT_NONE}, '{4'h8, 3'h3, 4'h7, ACT_NONE},
		'{4'h9, 3'h0, 4'h4, ACT_NONE}, '{4'hA, 3'h2, 4'h4, ACT_NONE},
		'{4'h7, 3'h0, 4'h0, ACT_NONE}};
	logic CLK, RST, req_valid, req_read, req_ready, rsp_done, rsp_fault;
	logic [3:0] req_crn, req_sel;
	logic [2:0] req_op2;
	logic [31:0] req_data, rsp_data, act_addr;
	logic wb_e, fb_e, mem_i, hit, vdirty, ev_d, cl_d, perr, fault_last;
	logic act_valid, alloc_dirty, alloc_main, probe, evict_req, clean_req;
	logic drain_req, dlock_mode;
	logic [TAG_W-1:0] alloc_tag;
	cmo_act_t act_code;
	int err_count, n_tests, act_cnt, done_cnt, done_base, a0, k;
	cmo_if link (.CLK(CLK));
	cmo_core cmo_core_i (.CLK(CLK), .RST(RST), .LINK(link),
		.REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_READ(req_read),
		.REQ_CRN(req_crn), .REQ_OP2(req_op2), .REQ_SEL(req_sel),
		.REQ_DATA(req_data), .RSP_DONE(rsp_done), .RSP_FAULT(rsp_fault),
		.RSP_DATA(rsp_data));
	cmo_engine cmo_engine_i (.CLK(CLK), .RST(RST), .LINK(link),
		.WBUF_EMPTY(wb_e), .FBUF_EMPTY(fb_e), .MEM_IDLE(mem_i),
		.DLINE_HIT(hit), .VICTIM_DIRTY(vdirty), .EVICT_DONE(ev_d),
		.CLEAN_DONE(cl_d), .CLEAN_PERR(perr), .ACT_VALID(act_valid),
		.ACT_CODE(act_code), .ACT_ADDR(act_addr), .ALLOC_TAG(alloc_tag),
		.ALLOC_DIRTY(alloc_dirty), .ALLOC_MAIN_ONLY(alloc_main),
		.PROBE(probe), .EVICT_REQ(evict_req), .CLEAN_REQ(clean_req),
		.DRAIN_REQ(drain_req), .DLOCK_MODE(dlock_mode));
	cmo_checker cmo_checker_i (.CLK(CLK), .RST(RST),
		.cmd_valid(link.cmd_valid), .cmd_ready(link.cmd_ready),
		.cmd_read(link.cmd_read), .cmd_crn(link.cmd_crn),
		.cmd_op2(link.cmd_op2), .operand_reg_select(link.operand_reg_select),
		.cmd_data(link.cmd_data), .done(link.done),
		.parity_fault(link.parity_fault), .rd_data(link.rd_data));
	initial begin
		CLK = 1'b0;
		forever #20 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		if (act_valid === 1'b1) act_cnt <= act_cnt + 1;
		if (rsp_done === 1'b1) begin
			done_cnt <= done_cnt + 1;
			fault_last <= rsp_fault;
		end
	end
	task print_verdict;
		$display("Checks %0d, errors %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task send(input logic rd, input logic [3:0] crn, input logic [2:0] op2,
		input logic [3:0] sel, input logic [31:0] d);
		int i;
		done_base = done_cnt;
		@(posedge CLK);
		req_valid <= 1'b1;
		req_read <= rd;
		req_crn <= crn;
		req_op2 <= op2;
		req_sel <= sel;
		req_data <= d;
		for (i = 0; i < 50; i++) begin
			@(negedge CLK);
			if (req_ready === 1'b1) break;
		end
		if (i == 50) begin
			err_count++;
			print_verdict;
		end
		@(posedge CLK);
		req_valid <= 1'b0;
	endtask
	task finish_cmd;
		int i;
		for (i = 0; i < 50 && done_cnt == done_base; i++) @(negedge CLK);
		if (done_cnt == done_base) begin
			err_count++;
			print_verdict;
		end
	endtask
	task run(input logic rd, input logic [3:0] crn, input logic [2:0] op2,
		input logic [3:0] sel, input logic [31:0] d);
		a0 = act_cnt;
		send(rd, crn, op2, sel, d);
		finish_cmd;
	endtask
	task wait_n(input int n);
		repeat (n) @(negedge CLK);
	endtask
	initial begin
		RST = 1'b1;
		{req_valid, req_read, req_crn, req_op2, req_sel, req_data} = '0;
		{wb_e, fb_e, mem_i, ev_d, cl_d, hit, vdirty, perr} = 8'hF8;
		{err_count, n_tests, act_cnt, done_cnt, done_base} = '0;
		repeat (8) @(posedge CLK);
		RST <= 1'b0;
		// Caches and translation are taken as enabled, so locks are legal
		for (k = 0; k < 18; k++) begin
			run(1'b0, TAB[k].crn, TAB[k].op2, TAB[k].sel, 32'hA5C3_0040 * k);
			chk(32'(act_cnt - a0), 32'h1);
			chk(32'(act_code), 32'(TAB[k].act));
			chk(act_addr, 32'hA5C3_0040 * k);
			chk(32'(fault_last), 32'h0);
		end
		for (k = 0; k < 5; k++) begin
			run(1'b0, BAD[k].crn, BAD[k].op2, BAD[k].sel, 32'h0000_00FF);
			chk(32'(act_cnt - a0), 32'h0);
		end
		run(1'b1, 4'h7, 3'h0, 4'h7, 32'h0);
		chk(32'(act_cnt - a0), 32'h0);
		run(1'b0, 4'h9, 3'h0, 4'h2, 32'h0000_0001);
		chk(32'(dlock_mode), 32'h1);
		run(1'b1, 4'h9, 3'h0, 4'h2, 32'h0);
		chk(rsp_data, 32'h0000_0001);
		run(1'b0, 4'h9, 3'h0, 4'h2, 32'hFFFF_FFFE);
		run(1'b1, 4'h9, 3'h0, 4'h2, 32'h0);
		chk(rsp_data, 32'h0);
		// Drain must hold until the fill buffer empties too
		@(posedge CLK);
		{wb_e, fb_e} <= 2'h0;
		send(1'b0, 4'h7, 3'h4, 4'hA, 32'h0);
		wait_n(4);
		chk(32'(drain_req), 32'h1);
		@(posedge CLK);
		wb_e <= 1'b1;
		wait_n(4);
		chk(32'(done_cnt - done_base), 32'h0);
		@(posedge CLK);
		fb_e <= 1'b1;
		finish_cmd;
		chk(32'(fault_last), 32'h0);
		@(posedge CLK);
		{mem_i, hit} <= 2'h1;
		a0 = act_cnt;
		send(1'b0, 4'h7, 3'h5, 4'h2, 32'h1357_9BE0);
		wait_n(4);
		chk(32'(done_cnt - done_base), 32'h0);
		@(posedge CLK);
		mem_i <= 1'b1;
		finish_cmd;
		chk(32'(act_cnt - a0), 32'h0);
		@(posedge CLK);
		{hit, vdirty, ev_d} <= 3'h2;
		a0 = act_cnt;
		send(1'b0, 4'h7, 3'h5, 4'h2, 32'h2468_ACE0);
		wait_n(4);
		chk(32'(evict_req), 32'h1);
		chk(32'(act_cnt - a0), 32'h0);
		@(posedge CLK);
		ev_d <= 1'b1;
		finish_cmd;
		chk(32'(act_cnt - a0), 32'h1);
		chk(32'(act_code), 32'(ACT_ALLOC));
		chk(32'(alloc_tag), 32'h2468_ACE0 >> 5);
		chk(32'(alloc_dirty), 32'h0);
		chk(32'(alloc_main), 32'h1);
		// Clean miss: allocate goes straight from the probe
		@(posedge CLK);
		{mem_i, vdirty} <= 2'h0;
		a0 = act_cnt;
		send(1'b0, 4'h7, 3'h5, 4'h2, 32'h0F0F_0F20);
		wait_n(2);
		chk(32'(probe), 32'h0);
		@(posedge CLK);
		mem_i <= 1'b1;
		wait_n(2);
		chk(32'(probe), 32'h1);
		finish_cmd;
		chk(32'(act_cnt - a0), 32'h1);
		chk(32'(alloc_tag), 32'h0F0F_0F20 >> 5);
		@(posedge CLK);
		{cl_d, perr} <= 2'h1;
		send(1'b0, 4'h7, 3'h1, 4'hA, 32'h0BAD_0040);
		wait_n(3);
		chk(32'(clean_req), 32'h1);
		@(posedge CLK);
		cl_d <= 1'b1;
		finish_cmd;
		chk(32'(fault_last), 32'h1);
		print_verdict;
	end
endmodule // tb
